// File: hw/api_pkg.sv
package api_pkg;

	// framing bytes
	localparam logic [7:0] DELIM     = 8'h7E;
	localparam logic [7:0] ESC       = 8'h7D;
	localparam logic [7:0] ESC_XOR   = 8'h20;
	localparam logic [7:0] XON       = 8'h11;
	localparam logic [7:0] XOFF      = 8'h13;
	localparam logic [7:0] CSUM_BASE = 8'hFF;

	// request frame types
	localparam logic [7:0] REQ_AT_NOW   = 8'h08;
	localparam logic [7:0] REQ_AT_QUEUE = 8'h09;
	localparam logic [7:0] REQ_TX       = 8'h10;
	localparam logic [7:0] REQ_TX_EXPL  = 8'h11;
	localparam logic [7:0] REQ_RCMD     = 8'h17;

	// response frame types
	localparam logic [7:0] RSP_MIN     = 8'h80;
	localparam logic [7:0] RSP_AT      = 8'h88;
	localparam logic [7:0] RSP_MODEM   = 8'h8A;
	localparam logic [7:0] RSP_TX      = 8'h8B;
	localparam logic [7:0] RSP_RX      = 8'h90;
	localparam logic [7:0] RSP_RX_EXPL = 8'h91;
	localparam logic [7:0] RSP_RCMD    = 8'h97;

	// frame layout: outgoing byte index and incoming frame-data index
	localparam logic [3:0] OFS_LEN_HI = 4'h1;
	localparam logic [3:0] OFS_LEN_LO = 4'h2;
	localparam logic [3:0] HDR_BYTES  = 4'h3;
	localparam logic [2:0] IDX_TYPE   = 3'h0;
	localparam logic [2:0] IDX_ID     = 3'h1;
	localparam logic [2:0] IDX_NAME0  = 3'h2;
	localparam logic [2:0] IDX_NAME1  = 3'h3;
	localparam logic [2:0] IDX_VALUE  = 3'h4;

	// accepted value widths in bytes, and the saturating limit of the value byte count
	localparam logic [2:0] VAL_ONE  = 3'h1;
	localparam logic [2:0] VAL_TWO  = 3'h2;
	localparam logic [2:0] VAL_FOUR = 3'h4;
	localparam logic [2:0] VAL_SAT  = 3'h7;

	// response lengths
	localparam int         RESP_MAX   = 6;
	localparam logic [3:0] RLEN_SHORT = 4'h2;
	localparam logic [3:0] RLEN_STAT  = 4'h3;
	localparam logic [3:0] RLEN_AT    = 4'h5;
	localparam logic [3:0] RLEN_AT_Q  = 4'h6;

	// command status codes and the modem frame error status
	localparam logic [7:0] ST_OK           = 8'h00;
	localparam logic [7:0] ST_BAD_CMD      = 8'h02;
	localparam logic [7:0] ST_BAD_PARAM    = 8'h03;
	localparam logic [7:0] MODEM_FRAME_ERR = 8'h01;

	// parameter table
	localparam int         NUM_PRM   = 4;
	localparam logic [1:0] PRM_HOP   = 2'h0;
	localparam logic [1:0] PRM_RATE  = 2'h1;
	localparam logic [1:0] PRM_FMT   = 2'h2;
	localparam logic [1:0] PRM_PROTO = 2'h3;
	localparam logic [NUM_PRM-1:0][15:0] PRM_NAMES = {16'h4150, 16'h414F, 16'h4244, 16'h4E48};
	localparam logic [NUM_PRM-1:0][7:0]  PRM_RESET = {8'h01, 8'h00, 8'h03, 8'h07};
	localparam logic [15:0] NAME_APPLY    = 16'h4143;
	localparam logic [7:0]  PROTO_ESCAPED = 8'h02;

	typedef enum logic [2:0] {
		HUNT   = 3'b000,
		LEN_HI = 3'b001,
		LEN_LO = 3'b011,
		BODY   = 3'b010,
		CHECK  = 3'b110,
		EXEC   = 3'b111,
		EMIT   = 3'b101
	} state_type;

endpackage

// File: hw/api_stream_if.sv
`timescale 1ns/10ps
interface api_stream_if #(
	parameter int WIDTH = 8
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface // api_stream_if

// File: hw/api_byte_fifo.sv
`timescale 1ns/10ps
module api_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// streams
	api_stream_if.snk in_s,
	api_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0]    cnt_reg, cnt_next;
	logic             ov_reg, ov_next;
	logic [WIDTH-1:0] od_reg, od_next;
	logic             push, pop;

	// output stage is a register so the consumer sees flop outputs
	assign in_s.ready  = (cnt_reg < CW'(DEPTH));
	assign out_s.valid = ov_reg;
	assign out_s.data  = od_reg;

	always_comb begin
		mem_next = mem_reg;
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		ov_next  = ov_reg;
		od_next  = od_reg;
		push     = in_s.valid && in_s.ready;
		pop      = (cnt_reg != '0) && (!ov_reg || out_s.ready);
		if (push) begin
			mem_next[wr_reg] = in_s.data;
			wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
		end
		if (pop) begin
			od_next = mem_reg[rd_reg];
			ov_next = 1'b1;
			rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
		end else if (out_s.ready) begin
			ov_next = 1'b0;
		end
		cnt_next = cnt_reg + CW'(push) - CW'(pop);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
			ov_reg  <= 1'b0;
			od_reg  <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
			ov_reg  <= ov_next;
			od_reg  <= od_next;
		end
		mem_reg <= mem_next;
	end
endmodule // api_byte_fifo

// File: hw/api_frame_command_handler.sv
`timescale 1ns/10ps
module api_frame_command_handler #(
	parameter int FIFO_DEPTH = 32
) (
	// clock and reset
	input  wire logic       I_SYS_CLK,
	input  wire logic       I_RESET,
	// host byte stream in
	input  wire logic       I_RX_VALID,
	input  wire logic [7:0] I_RX_DATA,
	output logic            O_RX_READY,
	// host byte stream out
	output logic            O_TX_VALID,
	output logic [7:0]      O_TX_DATA,
	input  wire logic       I_TX_READY,
	// radio transmit
	output logic            O_TX_REQ,
	input  wire logic       I_TX_DONE,
	input  wire logic [7:0] I_TX_STATUS,
	// remote command
	output logic            O_RCMD_REQ,
	input  wire logic       I_RCMD_DONE,
	input  wire logic       I_RCMD_RECEIVED,
	input  wire logic [7:0] I_RCMD_STATUS,
	// radio receive
	input  wire logic       I_RF_RX_VALID,
	input  wire logic [7:0] I_RF_RX_DATA,
	// active settings
	output logic [7:0]      O_HOP_LIMIT,
	output logic [7:0]      O_SERIAL_RATE,
	output logic [7:0]      O_RX_REPORT_FORMAT,
	output logic [7:0]      O_HOST_PROTOCOL
);
	api_pkg::state_type state_reg, state_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [2:0]  pos_reg, pos_next, vcnt_reg, vcnt_next;
	logic [7:0]  len_hi_reg, len_hi_next, sum_reg, sum_next;
	logic        esc_reg, esc_next, vhi_reg, vhi_next;
	logic [7:0]  type_reg, type_next, id_reg, id_next, val_reg, val_next;
	logic [7:0]  name0_reg, name0_next, name1_reg, name1_next;
	logic [7:0]  tx_id_reg, tx_id_next, rcmd_id_reg, rcmd_id_next;
	logic        tx_req_reg, tx_req_next, rcmd_req_reg, rcmd_req_next;
	logic        rx_ready_reg, rx_ready_next, stuff_reg, stuff_next;
	logic [api_pkg::RESP_MAX-1:0][7:0] rbuf_reg, rbuf_next;
	logic [3:0]  rlen_reg, rlen_next, eidx_reg, eidx_next, bidx;
	logic [7:0]  osum_reg, osum_next;
	logic [api_pkg::NUM_PRM-1:0][7:0] act_reg, act_next, pend_reg, pend_next;
	logic [api_pkg::NUM_PRM-1:0] pflag_reg, pflag_next, hit_vec;
	logic        ev_err_reg, ev_err_next, ev_tx_reg, ev_tx_next;
	logic        ev_rcmd_reg, ev_rcmd_next, ev_rx_reg, ev_rx_next;
	logic [7:0]  tx_stat_reg, tx_stat_next, rcmd_stat_reg, rcmd_stat_next;
	logic [7:0]  rx_byte_reg, rx_byte_next;
	logic        rx_take, escaped, d_ok, err_set, emit_go, is_at, is_apply, val_ok;
	logic        clr_err, clr_tx, clr_rcmd, clr_rx, sel_tx, sel_rx, need_esc;
	logic [1:0]  hidx;
	logic [7:0]  d, raw, obyte;

	api_stream_if #(.WIDTH(8)) push_s ();
	api_stream_if #(.WIDTH(8)) pop_s ();

	api_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_out_fifo (
		.i_clk   (I_SYS_CLK),
		.i_reset (I_RESET),
		.in_s    (push_s),
		.out_s   (pop_s)
	);

	assign push_s.valid = (state_reg == api_pkg::EMIT);
	assign push_s.data  = obyte;
	assign pop_s.ready  = I_TX_READY;
	assign O_TX_VALID   = pop_s.valid;
	assign O_TX_DATA    = pop_s.data;
	assign O_RX_READY   = rx_ready_reg;
	assign O_TX_REQ     = tx_req_reg;
	assign O_RCMD_REQ   = rcmd_req_reg;
	// settings leave from the active copy only, pending values stay hidden
	assign O_HOP_LIMIT        = act_reg[api_pkg::PRM_HOP];
	assign O_SERIAL_RATE      = act_reg[api_pkg::PRM_RATE];
	assign O_RX_REPORT_FORMAT = act_reg[api_pkg::PRM_FMT];
	assign O_HOST_PROTOCOL    = act_reg[api_pkg::PRM_PROTO];

	assign rx_take  = I_RX_VALID && rx_ready_reg;
	assign escaped  = (act_reg[api_pkg::PRM_PROTO] == api_pkg::PROTO_ESCAPED);
	assign is_at    = (type_reg == api_pkg::REQ_AT_NOW) || (type_reg == api_pkg::REQ_AT_QUEUE);
	assign is_apply = ({name0_reg, name1_reg} == api_pkg::NAME_APPLY);
	// zero padding above the last byte is allowed, so 1, 2 and 4 bytes decode alike
	assign val_ok   = !vhi_reg && ((vcnt_reg == api_pkg::VAL_ONE) ||
		(vcnt_reg == api_pkg::VAL_TWO) || (vcnt_reg == api_pkg::VAL_FOUR));

	// parameter name match, one comparator per table entry
	for (genvar g = 0; g < api_pkg::NUM_PRM; g++) begin : g_match
		assign hit_vec[g] = ({name0_reg, name1_reg} == api_pkg::PRM_NAMES[g]);
	end

	always_comb begin
		hidx = '0;
		for (int i = 0; i < api_pkg::NUM_PRM; i++) begin
			if (hit_vec[i]) begin
				hidx = i[1:0];
			end
		end
	end

	// outgoing byte, escaped when the host protocol asks for it
	always_comb begin
		bidx = eidx_reg - api_pkg::HDR_BYTES;
		if (eidx_reg == '0) begin
			raw = api_pkg::DELIM;
		end else if (eidx_reg == api_pkg::OFS_LEN_HI) begin
			raw = '0;
		end else if (eidx_reg == api_pkg::OFS_LEN_LO) begin
			raw = {4'h0, rlen_reg};
		end else if (eidx_reg == rlen_reg + api_pkg::HDR_BYTES) begin
			raw = api_pkg::CSUM_BASE - osum_reg;
		end else begin
			raw = rbuf_reg[bidx[2:0]];
		end
		need_esc = escaped && (eidx_reg != '0) && ((raw == api_pkg::DELIM) ||
			(raw == api_pkg::ESC) || (raw == api_pkg::XON) || (raw == api_pkg::XOFF));
		obyte = stuff_reg ? (raw ^ api_pkg::ESC_XOR) : (need_esc ? api_pkg::ESC : raw);
	end

	always_comb begin
		state_next = state_reg;    cnt_next = cnt_reg;       pos_next = pos_reg;
		vcnt_next = vcnt_reg;      len_hi_next = len_hi_reg; sum_next = sum_reg;
		esc_next = esc_reg;        vhi_next = vhi_reg;       type_next = type_reg;
		id_next = id_reg;          val_next = val_reg;       name0_next = name0_reg;
		name1_next = name1_reg;    tx_id_next = tx_id_reg;   rcmd_id_next = rcmd_id_reg;
		stuff_next = stuff_reg;    rbuf_next = rbuf_reg;     rlen_next = rlen_reg;
		eidx_next = eidx_reg;      osum_next = osum_reg;     act_next = act_reg;
		pend_next = pend_reg;      pflag_next = pflag_reg;
		tx_req_next = 1'b0;        rcmd_req_next = 1'b0;     err_set = 1'b0;
		clr_err = 1'b0;            clr_tx = 1'b0;            clr_rcmd = 1'b0;
		clr_rx = 1'b0;             sel_tx = 1'b0;            sel_rx = 1'b0;
		emit_go = 1'b0;            d_ok = 1'b0;              d = I_RX_DATA;
		if (rx_take && state_reg != api_pkg::HUNT) begin
			if (escaped && I_RX_DATA == api_pkg::DELIM) begin
				state_next = api_pkg::LEN_HI;
				esc_next = 1'b0;
			end else if (escaped && I_RX_DATA == api_pkg::ESC && !esc_reg) begin
				esc_next = 1'b1;
			end else begin
				d_ok = 1'b1;
				esc_next = 1'b0;
				d = esc_reg ? (I_RX_DATA ^ api_pkg::ESC_XOR) : I_RX_DATA;
			end
		end
		case (state_reg)
			api_pkg::HUNT: begin
				if (rx_take && I_RX_DATA == api_pkg::DELIM) begin
					state_next = api_pkg::LEN_HI;
					esc_next = 1'b0;
				end else if (ev_err_reg) begin
					clr_err = 1'b1;
					rbuf_next[0] = api_pkg::RSP_MODEM;
					rbuf_next[1] = api_pkg::MODEM_FRAME_ERR;
					rlen_next = api_pkg::RLEN_SHORT;
					emit_go = 1'b1;
				end else if (ev_tx_reg) begin
					clr_tx = 1'b1;
					sel_tx = 1'b1;
					rbuf_next[0] = api_pkg::RSP_TX;
					rbuf_next[1] = tx_id_reg;
					rbuf_next[2] = tx_stat_reg;
					rlen_next = api_pkg::RLEN_STAT;
					emit_go = 1'b1;
				end else if (ev_rcmd_reg) begin
					clr_rcmd = 1'b1;
					rbuf_next[0] = api_pkg::RSP_RCMD;
					rbuf_next[1] = rcmd_id_reg;
					rbuf_next[2] = rcmd_stat_reg;
					rlen_next = api_pkg::RLEN_STAT;
					emit_go = 1'b1;
				end else if (ev_rx_reg) begin
					clr_rx = 1'b1;
					sel_rx = 1'b1;
					rbuf_next[0] = (act_reg[api_pkg::PRM_FMT] != '0) ?
						api_pkg::RSP_RX_EXPL : api_pkg::RSP_RX;
					rbuf_next[1] = rx_byte_reg;
					rlen_next = api_pkg::RLEN_SHORT;
					emit_go = 1'b1;
				end
			end
			api_pkg::LEN_HI: begin
				if (d_ok) begin
					len_hi_next = d;
					state_next = api_pkg::LEN_LO;
				end
			end
			api_pkg::LEN_LO: begin
				if (d_ok) begin
					cnt_next = {len_hi_reg, d};
					sum_next = '0;
					val_next = '0; // stale value would flag padding as nonzero
					pos_next = '0;
					vcnt_next = '0;
					vhi_next = 1'b0;
					state_next = ({len_hi_reg, d} == '0) ? api_pkg::HUNT : api_pkg::BODY;
					err_set = ({len_hi_reg, d} == '0);
				end
			end
			api_pkg::BODY: begin
				if (d_ok) begin
					sum_next = sum_reg + d;
					cnt_next = cnt_reg - 1'b1;
					if (cnt_reg == 16'h0001) begin
						state_next = api_pkg::CHECK;
					end
					if (pos_reg == api_pkg::IDX_VALUE) begin
						vhi_next = vhi_reg | (val_reg != '0);
						val_next = d;
						vcnt_next = (vcnt_reg == api_pkg::VAL_SAT) ? vcnt_reg : vcnt_reg + 1'b1;
					end else begin
						pos_next = pos_reg + 1'b1;
					end
					if (pos_reg == api_pkg::IDX_TYPE) type_next = d;
					if (pos_reg == api_pkg::IDX_ID) id_next = d;
					if (pos_reg == api_pkg::IDX_NAME0) name0_next = d;
					if (pos_reg == api_pkg::IDX_NAME1) name1_next = d;
				end
			end
			api_pkg::CHECK: begin
				if (d_ok) begin
					if (8'(sum_reg + d) == api_pkg::CSUM_BASE) begin
						state_next = api_pkg::EXEC;
					end else begin
						state_next = api_pkg::HUNT;
						err_set = 1'b1;
					end
				end
			end
			api_pkg::EXEC: begin
				state_next = api_pkg::HUNT;
				if (is_at) begin
					rbuf_next[0] = api_pkg::RSP_AT;
					rbuf_next[1] = id_reg;
					rbuf_next[2] = name0_reg;
					rbuf_next[3] = name1_reg;
					rbuf_next[4] = api_pkg::ST_OK;
					rbuf_next[5] = '0;
					rlen_next = api_pkg::RLEN_AT;
					if (is_apply) begin
						rbuf_next[4] = api_pkg::ST_OK;
					end else if (!(|hit_vec)) begin
						rbuf_next[4] = api_pkg::ST_BAD_CMD;
					end else if (vcnt_reg == '0) begin
						rbuf_next[5] = act_reg[hidx];
						rlen_next = api_pkg::RLEN_AT_Q;
					end else if (val_ok) begin
						pend_next[hidx] = val_reg;
						pflag_next[hidx] = 1'b1;
					end else begin
						rbuf_next[4] = api_pkg::ST_BAD_PARAM;
					end
					if (type_reg == api_pkg::REQ_AT_NOW || is_apply) begin
						for (int i = 0; i < api_pkg::NUM_PRM; i++) begin
							if (pflag_next[i]) act_next[i] = pend_next[i];
						end
						pflag_next = '0;
					end
					emit_go = (id_reg != '0);
				end else if (type_reg == api_pkg::REQ_TX || type_reg == api_pkg::REQ_TX_EXPL) begin
					tx_req_next = 1'b1;
					tx_id_next = id_reg;
				end else if (type_reg == api_pkg::REQ_RCMD) begin
					rcmd_req_next = 1'b1;
					rcmd_id_next = id_reg;
				end
				// any other type, including response codes, is dropped
			end
			api_pkg::EMIT: begin
				if (push_s.ready) begin
					if (need_esc && !stuff_reg) begin
						stuff_next = 1'b1;
					end else begin
						stuff_next = 1'b0;
						osum_next = (eidx_reg >= api_pkg::HDR_BYTES) ? osum_reg + raw : osum_reg;
						if (eidx_reg == rlen_reg + api_pkg::HDR_BYTES) begin
							state_next = api_pkg::HUNT;
						end else begin
							eidx_next = eidx_reg + 1'b1;
						end
					end
				end
			end
			default: begin
				state_next = api_pkg::HUNT;
			end
		endcase
		if (emit_go) begin
			state_next = api_pkg::EMIT;
			eidx_next = '0;
			osum_next = '0;
			stuff_next = 1'b0;
		end
		rx_ready_next = (state_next != api_pkg::EXEC) && (state_next != api_pkg::EMIT);
	end

	// a second event of one kind before service overwrites the held data
	always_comb begin
		ev_err_next  = err_set | (ev_err_reg & ~clr_err);
		ev_tx_next   = (I_TX_DONE && tx_id_reg != '0) | (ev_tx_reg & ~clr_tx);
		ev_rcmd_next = (I_RCMD_DONE && I_RCMD_RECEIVED && rcmd_id_reg != '0) |
			(ev_rcmd_reg & ~clr_rcmd);
		ev_rx_next     = I_RF_RX_VALID | (ev_rx_reg & ~clr_rx);
		tx_stat_next   = I_TX_DONE ? I_TX_STATUS : tx_stat_reg;
		rcmd_stat_next = I_RCMD_DONE ? I_RCMD_STATUS : rcmd_stat_reg;
		rx_byte_next   = I_RF_RX_VALID ? I_RF_RX_DATA : rx_byte_reg;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			state_reg <= api_pkg::HUNT; cnt_reg <= '0;     pos_reg <= '0;
			vcnt_reg <= '0;            len_hi_reg <= '0;  sum_reg <= '0;
			esc_reg <= 1'b0;           vhi_reg <= 1'b0;   type_reg <= '0;
			id_reg <= '0;              val_reg <= '0;     name0_reg <= '0;
			name1_reg <= '0;           tx_id_reg <= '0;   rcmd_id_reg <= '0;
			tx_req_reg <= 1'b0;        rcmd_req_reg <= 1'b0;
			rx_ready_reg <= 1'b0;      stuff_reg <= 1'b0; rbuf_reg <= '0;
			rlen_reg <= '0;            eidx_reg <= '0;    osum_reg <= '0;
			act_reg <= api_pkg::PRM_RESET;
			pend_reg <= api_pkg::PRM_RESET;
			pflag_reg <= '0;
			ev_err_reg <= 1'b0;        ev_tx_reg <= 1'b0; ev_rcmd_reg <= 1'b0;
			ev_rx_reg <= 1'b0;         tx_stat_reg <= '0; rcmd_stat_reg <= '0;
			rx_byte_reg <= '0;
		end else begin
			state_reg <= state_next;   cnt_reg <= cnt_next;       pos_reg <= pos_next;
			vcnt_reg <= vcnt_next;     len_hi_reg <= len_hi_next; sum_reg <= sum_next;
			esc_reg <= esc_next;       vhi_reg <= vhi_next;       type_reg <= type_next;
			id_reg <= id_next;         val_reg <= val_next;       name0_reg <= name0_next;
			name1_reg <= name1_next;   tx_id_reg <= tx_id_next;   rcmd_id_reg <= rcmd_id_next;
			tx_req_reg <= tx_req_next; rcmd_req_reg <= rcmd_req_next;
			rx_ready_reg <= rx_ready_next; stuff_reg <= stuff_next; rbuf_reg <= rbuf_next;
			rlen_reg <= rlen_next;     eidx_reg <= eidx_next;     osum_reg <= osum_next;
			act_reg <= act_next;       pend_reg <= pend_next;     pflag_reg <= pflag_next;
			ev_err_reg <= ev_err_next; ev_tx_reg <= ev_tx_next;   ev_rcmd_reg <= ev_rcmd_next;
			ev_rx_reg <= ev_rx_next;   tx_stat_reg <= tx_stat_next;
			rcmd_stat_reg <= rcmd_stat_next;
			rx_byte_reg <= rx_byte_next;
		end
	end

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);

	sequence s_at_exec;
		(state_reg == api_pkg::EXEC) && is_at;
	endsequence
	sequence s_emit_head;
		(state_reg == api_pkg::EMIT) && (eidx_reg == '0) && !stuff_reg;
	endsequence

	property p_silent_id;
		(s_at_exec ##0 (id_reg == '0)) |=> (state_reg == api_pkg::HUNT);
	endproperty
	a_silent_id: assert property (p_silent_id) else $error("zero id got a reply");
	property p_tx_status;
		(I_TX_DONE && tx_id_reg != '0) |=> ev_tx_reg;
	endproperty
	a_tx_status: assert property (p_tx_status) else $error("tx status lost");
	property p_tx_reason;
		sel_tx |=> (rbuf_reg[2] == $past(tx_stat_reg)) && (state_reg == api_pkg::EMIT);
	endproperty
	a_tx_reason: assert property (p_tx_reason) else $error("tx cause not carried");
	property p_rx_format;
		sel_rx |=> (rbuf_reg[0] == ((act_reg[api_pkg::PRM_FMT] != '0) ?
			api_pkg::RSP_RX_EXPL : api_pkg::RSP_RX));
	endproperty
	a_rx_format: assert property (p_rx_format) else $error("wrong rx frame type");
	property p_rcmd_gate;
		(I_RCMD_DONE && !I_RCMD_RECEIVED && !ev_rcmd_reg) |=> !ev_rcmd_reg;
	endproperty
	a_rcmd_gate: assert property (p_rcmd_gate) else $error("remote reply not gated");
	property p_apply_now;
		(state_reg == api_pkg::EXEC && type_reg == api_pkg::REQ_AT_NOW) |=> (pflag_reg == '0);
	endproperty
	a_apply_now: assert property (p_apply_now) else $error("changes left pending");
	property p_id_echo;
		(s_at_exec ##0 (id_reg != '0)) |=> (rbuf_reg[1] == $past(id_reg)) &&
			(rbuf_reg[0] == api_pkg::RSP_AT) ##1 (state_reg == api_pkg::EMIT);
	endproperty
	a_id_echo: assert property (p_id_echo) else $error("identifier not echoed");
	property p_query_now;
		(s_at_exec ##0 (|hit_vec && vcnt_reg == '0)) |=> (rlen_reg == api_pkg::RLEN_AT_Q);
	endproperty
	a_query_now: assert property (p_query_now) else $error("query not answered");
	property p_bad_frame;
		err_set |=> ev_err_reg && (state_reg == api_pkg::HUNT);
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("bad frame not flagged");
	property p_queue_hold;
		(state_reg == api_pkg::EXEC && type_reg == api_pkg::REQ_AT_QUEUE && !is_apply)
			|=> $stable(act_reg);
	endproperty
	a_queue_hold: assert property (p_queue_hold) else $error("queued value applied");
	property p_resp_type;
		s_emit_head |-> (rbuf_reg[0] >= api_pkg::RSP_MIN) && (push_s.data == api_pkg::DELIM);
	endproperty
	a_resp_type: assert property (p_resp_type) else $error("bad response head");
	property p_drop_junk;
		(state_reg == api_pkg::HUNT && rx_take && I_RX_DATA != api_pkg::DELIM &&
			!ev_err_reg && !ev_tx_reg && !ev_rcmd_reg && !ev_rx_reg) |=> (state_reg == api_pkg::HUNT);
	endproperty
	a_drop_junk: assert property (p_drop_junk) else $error("junk byte started frame");
endmodule // api_frame_command_handler

// File: testbench/api_host_model.sv
`timescale 1ns/10ps
module api_host_model (
	// clock
	input  wire logic       i_clk,
	// response stream from the device
	input  wire logic       i_valid,
	input  wire logic [7:0] i_data,
	output logic            o_ready
);
	logic [7:0] got[$];
	initial o_ready = 1'b0;
	// random stalls make the fifo hold bytes back
	always @(posedge i_clk) begin
		if (i_valid && o_ready)
			got.push_back(i_data);
		o_ready <= ($urandom % 3) != 0;
	end
endmodule // api_host_model

// File: testbench/api_frame_command_handler_tb.sv
`timescale 1ns/10ps
module api_frame_command_handler_tb;
	logic       clk = 1'b0, rst = 1'b1, rx_valid = 1'b0, rx_ready, tx_valid, tx_ready;
	logic       tx_req, tx_done = 1'b0, rf_valid = 1'b0;
	logic [7:0] rx_data = 8'h00, tx_data, tx_status = 8'h00, rf_data = 8'h00;
	logic [7:0] hop, rate, fmt, proto, rcmd_st = 8'h00;
	logic       rcmd_req, rcmd_done = 1'b0, rcmd_rcv = 1'b0;
	bit         esc = 1'b0;
	typedef logic [7:0] bytes_type[$];
	int         mismatches = 0, n_tests = 0;
	always #20 clk = ~clk;
	api_frame_command_handler #(.FIFO_DEPTH(32)) dut (.I_SYS_CLK(clk), .I_RESET(rst),
		.I_RX_VALID(rx_valid), .I_RX_DATA(rx_data), .O_RX_READY(rx_ready),
		.O_TX_VALID(tx_valid), .O_TX_DATA(tx_data), .I_TX_READY(tx_ready),
		.O_TX_REQ(tx_req), .I_TX_DONE(tx_done), .I_TX_STATUS(tx_status), .O_RCMD_REQ(rcmd_req),
		.I_RCMD_DONE(rcmd_done), .I_RCMD_RECEIVED(rcmd_rcv), .I_RCMD_STATUS(rcmd_st),
		.I_RF_RX_VALID(rf_valid), .I_RF_RX_DATA(rf_data), .O_HOP_LIMIT(hop),
		.O_SERIAL_RATE(rate), .O_RX_REPORT_FORMAT(fmt), .O_HOST_PROTOCOL(proto));
	api_host_model host (.i_clk(clk), .i_valid(tx_valid), .i_data(tx_data), .o_ready(tx_ready));
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang();
		mismatches++;
		end_sim();
	endtask
	function automatic logic [7:0] csum(input logic [7:0] d[$]);
		logic [7:0] s = 8'h00;
		foreach (d[i]) s += d[i];
		return 8'hFF - s;
	endfunction
	// wire image of a frame, the delimiter itself is never escaped
	function automatic bytes_type wire_of(input logic [7:0] f[$], input bit e);
		bytes_type w;
		foreach (f[i]) begin
			if (e && i > 0 && (f[i] == 8'h7E || f[i] == 8'h7D || f[i] == 8'h11 || f[i] == 8'h13)) begin
				w.push_back(8'h7D);
				w.push_back(f[i] ^ 8'h20);
			end else begin
				w.push_back(f[i]);
			end
		end
		return w;
	endfunction
	// each byte is held until the parser takes it
	task automatic put(input logic [7:0] b);
		int n;
		rx_valid <= 1'b1;
		rx_data  <= b;
		n = 0;
		// the byte is taken at the edge where ready is sampled high
		do begin
			@(posedge clk);
			n++;
		end while (rx_ready !== 1'b1 && n < 300);
		if (rx_ready !== 1'b1) hang();
	endtask
	task automatic send(input logic [7:0] d[$], input logic [7:0] bad);
		logic [7:0] f[$];
		f = {8'h7E, 8'h00, 8'(d.size()), d, csum(d) ^ bad};
		f = wire_of(f, esc);
		foreach (f[i]) put(f[i]);
		rx_valid <= 1'b0;
	endtask
	task automatic expect_frame(input logic [7:0] d[$]);
		logic [7:0] e[$];
		int         n;
		e = {8'h7E, 8'h00, 8'(d.size()), d, csum(d)};
		e = wire_of(e, esc);
		for (n = 0; n < 400 && host.got.size() < e.size(); n++) @(posedge clk);
		if (n == 400) hang();
		foreach (e[i]) chk("response byte", e[i], host.got[i]);
		host.got.delete();
	endtask
	initial begin
		logic [7:0] id, st;
		int         n;
		void'($urandom(32'h627386B9));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("format reset", 8'h00, fmt);
		chk("protocol reset", 8'h01, proto);
		id = 8'($urandom_range(1, 255));
		put(8'h13);
		send({8'h08, id, 8'h4E, 8'h48}, 8'h00);
		expect_frame({8'h88, id, 8'h4E, 8'h48, 8'h00, 8'h07});
		send({8'h09, 8'h00, 8'h42, 8'h44, 8'h07}, 8'h00);
		repeat (60) @(posedge clk);
		chk("silent frame", 8'h00, 8'(host.got.size()));
		chk("rate pending", 8'h03, rate);
		send({8'h08, id, 8'h4E, 8'h48, 8'h00, 8'h00, 8'h00, 8'h05}, 8'h00);
		expect_frame({8'h88, id, 8'h4E, 8'h48, 8'h00});
		chk("rate applied", 8'h07, rate);
		chk("hop padded", 8'h05, hop);
		st = 8'($urandom_range(1, 255));
		send({8'h10, id, 8'hA5}, 8'h00);
		for (n = 0; n < 100 && tx_req !== 1'b1; n++) @(posedge clk);
		if (n == 100) hang();
		tx_done   <= 1'b1;
		tx_status <= st;
		@(posedge clk);
		tx_done <= 1'b0;
		expect_frame({8'h8B, id, st});
		send({8'h08, id, 8'h4E, 8'h48}, 8'h5A);
		expect_frame({8'h8A, 8'h01});
		rf_valid <= 1'b1;
		rf_data  <= st;
		@(posedge clk);
		rf_valid <= 1'b0;
		expect_frame({8'h90, st});
		send({8'h17, id, 8'hA5}, 8'h00);
		for (n = 0; n < 100 && rcmd_req !== 1'b1; n++) @(posedge clk);
		if (n == 100) hang();
		rcmd_done <= 1'b1;
		@(posedge clk);
		rcmd_done <= 1'b0;
		repeat (60) @(posedge clk);
		chk("remote silent", 8'h00, 8'(host.got.size()));
		rcmd_done <= 1'b1;
		rcmd_rcv  <= 1'b1;
		rcmd_st   <= st;
		@(posedge clk);
		rcmd_done <= 1'b0;
		expect_frame({8'h97, id, st});
		send({8'h08, 8'h00, 8'h41, 8'h4F, 8'h01}, 8'h00);
		repeat (20) @(posedge clk);
		chk("format", 8'h01, fmt);
		rf_valid <= 1'b1;
		rf_data  <= id;
		@(posedge clk);
		rf_valid <= 1'b0;
		expect_frame({8'h91, id});
		send({8'h08, 8'h00, 8'h41, 8'h50, 8'h02}, 8'h00);
		repeat (20) @(posedge clk);
		chk("protocol", 8'h02, proto);
		esc = 1'b1;
		// identifier chosen as a reserved byte so both directions must escape it
		send({8'h08, 8'h7D, 8'h4E, 8'h48}, 8'h00);
		expect_frame({8'h88, 8'h7D, 8'h4E, 8'h48, 8'h00, 8'h05});
		end_sim();
	end
endmodule // api_frame_command_handler_tb
